// >>> logic/gppc_pkg.sv
// constants, register map and bus carrier for the general port pin control
// assumes a single system clock and a plain strobe register port
package gppc_pkg;
  localparam int unsigned GPPC_MAX_PORTS = 12;
  localparam int unsigned GPPC_PINS      = 8;
  localparam int unsigned GPPC_AW        = 8;
  localparam int unsigned GPPC_DW        = 16;
  localparam int unsigned GPPC_ALT_FUNCS = 7;

  // register map: addr[7:4] port, addr[3:0] register
  localparam logic [3:0] GPPC_REG_DOUT   = 4'h8;
  localparam logic [3:0] GPPC_REG_DIN    = 4'h9;
  localparam logic [3:0] GPPC_REG_PMD    = 4'hA;
  localparam logic [3:0] GPPC_REG_PSL    = 4'hB;
  localparam logic [3:0] GPPC_GLOBAL     = 4'hF;
  localparam logic [3:0] GPPC_REG_CLKSEL = 4'h0;
  localparam logic [3:0] GPPC_REG_XTMODE = 4'h1;
  localparam logic [3:0] GPPC_REG_XTDIN  = 4'h2;

  // pin mode field positions
  localparam int unsigned GPPC_IE_BIT    = 0;
  localparam int unsigned GPPC_OE_BIT    = 1;
  localparam int unsigned GPPC_PU_BIT    = 2;
  localparam int unsigned GPPC_OD_BIT    = 3;
  localparam int unsigned GPPC_FN_LSB    = 4;
  localparam int unsigned GPPC_FN_W      = 4;
  localparam int unsigned GPPC_PMD_LVL   = 8;

  // reset values
  localparam logic [7:0]  GPPC_MODE_RST  = 8'h00;
  localparam logic [7:0]  GPPC_BOOT_RST  = 8'h05;
  localparam logic [7:0]  GPPC_DOUT_RST  = 8'h00;
  localparam logic [15:0] GPPC_PMD_RST   = 16'h0000;
  localparam logic [7:0]  GPPC_PSL_RST   = 8'h00;
  localparam int unsigned GPPC_BOOT_PIN  = 1;
  localparam int unsigned GPPC_TEST_PIN  = 0;

  typedef enum logic [3:0] {
    GPPC_FN_PRIMARY = 4'b0000,
    GPPC_FN_LAST    = 4'b0111
  } gppc_fn_type;

  typedef struct packed {
    logic [GPPC_AW-1:0] addr;
    logic [GPPC_DW-1:0] wdata;
    logic               wr;
    logic               rd;
  } gppc_bus_req_type;
endpackage : gppc_pkg

// >>> logic/gppc_port_ctrl.sv
// per-pin mode, data, carrier and loop-back logic for the general ports
// assumes pins arrive asynchronously; timers and peripherals share clk
module gppc_port_ctrl
  import gppc_pkg::*;
#(
  parameter int unsigned NPORTS   = 12,
  parameter int unsigned NCARRIER = 4
) (
  input  wire logic                                clk,
  input  wire logic                                rst,
  input  wire gppc_pkg::gppc_bus_req_type          bus_req,
  output logic [gppc_pkg::GPPC_DW-1:0]             bus_rdata,
  input  wire logic [NPORTS*gppc_pkg::GPPC_PINS-1:0] pin_in,
  output logic [NPORTS*gppc_pkg::GPPC_PINS-1:0]    pin_out,
  output logic [NPORTS*gppc_pkg::GPPC_PINS-1:0]    pin_oe,
  output logic [NPORTS*gppc_pkg::GPPC_PINS-1:0]    pin_pullup,
  input  wire logic [NPORTS*gppc_pkg::GPPC_PINS-1:0][gppc_pkg::GPPC_ALT_FUNCS-1:0] alt_out,
  output logic [NPORTS*gppc_pkg::GPPC_PINS-1:0][gppc_pkg::GPPC_FN_W-1:0] func_sel,
  output logic [NPORTS*gppc_pkg::GPPC_PINS-1:0]    periph_in,
  input  wire logic                                timer0_out,
  input  wire logic                                ftimer0_out,
  input  wire logic                                debug_active,
  input  wire logic [1:0]                          xt_pin_in,
  output logic [1:0]                               xt_in_en
);
  import gppc_pkg::*;

  localparam int unsigned NPIN = NPORTS * GPPC_PINS;
  localparam int unsigned NCR  = (NCARRIER == 0) ? 1 : NCARRIER;

  //////////////////////////////////////////////////////////////////////////////
  // port count check
  if (NPORTS < 1 || NPORTS > GPPC_MAX_PORTS || NCARRIER > NPORTS) begin : g_bad
    $error("gppc_port_ctrl: unsupported port or carrier count");
  end

  typedef struct packed {
    logic [NPIN-1:0][7:0]   mode;
    logic [NPORTS-1:0][7:0] dout;
    logic [NCR-1:0][15:0]   pmd;
    logic [NCR-1:0][7:0]    psl;
    logic                   clk_sel;
    logic [1:0]             xt_mode;
    logic [NPIN-1:0]        sync1;
    logic [NPIN-1:0]        sync2;
    logic [1:0]             xsync1;
    logic [1:0]             xsync2;
    logic [NPIN-1:0]        drv_lvl;
    logic [NPIN-1:0]        pad_out;
    logic [NPIN-1:0]        pad_oe;
    logic [NPIN-1:0]        pad_pu;
    logic [NPIN-1:0]        pin_fn_in;
    logic [1:0]             xt_en;
    logic [GPPC_DW-1:0]     rdata;
  } gppc_state_type;

  gppc_state_type st_r;
  gppc_state_type st_nxt;

  //////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    logic [3:0]         port_a;
    logic [3:0]         reg_a;
    logic [7:0]         md;
    logic [3:0]         fn;
    logic               base;
    logic               lvl;
    logic               car;
    logic               ie;
    logic               oe;
    logic [GPPC_DW-1:0] rd;
    int unsigned        p;
    int unsigned        m;
    port_a = bus_req.addr[7:4];
    reg_a  = bus_req.addr[3:0];
    md     = 8'h00;
    fn     = 4'h0;
    base   = 1'b0;
    lvl    = 1'b0;
    car    = 1'b0;
    ie     = 1'b0;
    oe     = 1'b0;
    rd     = 16'h0000;
    p      = 0;
    m      = 0;
    st_nxt = st_r;

    // two-stage synchronisers
    st_nxt.sync1  = pin_in;
    st_nxt.sync2  = st_r.sync1;
    st_nxt.xsync1 = xt_pin_in;
    st_nxt.xsync2 = st_r.xsync1;

    // register writes
    if (bus_req.wr) begin
      if (port_a == GPPC_GLOBAL) begin
        if (reg_a == GPPC_REG_CLKSEL) begin
          st_nxt.clk_sel = bus_req.wdata[0];
        end
        if (reg_a == GPPC_REG_XTMODE) begin
          st_nxt.xt_mode = {bus_req.wdata[8], bus_req.wdata[0]};
        end
      end else if (32'(port_a) < NPORTS) begin
        if (reg_a < GPPC_REG_DOUT) begin
          st_nxt.mode[32'(port_a) * GPPC_PINS + 32'(reg_a)] = bus_req.wdata[7:0];
        end
        if (reg_a == GPPC_REG_DOUT) begin
          st_nxt.dout[port_a] = bus_req.wdata[7:0];
        end
        if (32'(port_a) < NCARRIER && reg_a == GPPC_REG_PMD) begin
          st_nxt.pmd[port_a] = bus_req.wdata;
        end
        if (32'(port_a) < NCARRIER && reg_a == GPPC_REG_PSL) begin
          st_nxt.psl[port_a] = bus_req.wdata[7:0];
        end
      end
    end

    // pin datapath
    for (int unsigned i = 0; i < NPIN; i++) begin
      p  = i / GPPC_PINS;
      m  = i % GPPC_PINS;
      md = st_r.mode[i];
      fn = md[GPPC_FN_LSB +: GPPC_FN_W];
      ie = md[GPPC_IE_BIT];
      oe = md[GPPC_OE_BIT];
      if (fn != GPPC_FN_PRIMARY && fn <= GPPC_FN_LAST) begin
        base = alt_out[i][fn[2:0] - 3'd1];
      end else begin
        base = st_r.dout[p][m];
      end
      lvl = base;
      if (p < NCARRIER) begin
        // 0 timer 0, 1 functional timer
        car = st_r.psl[p][m] ? ftimer0_out : timer0_out;
        if (st_r.pmd[p][m]) begin
          if (st_r.pmd[p][GPPC_PMD_LVL + m]) begin
            lvl = base | car;
          end else begin
            lvl = base & car;
          end
        end
      end
      if (i == GPPC_TEST_PIN && debug_active) begin
        oe = 1'b0;
        ie = 1'b0;
      end
      st_nxt.drv_lvl[i] = lvl;
      // released when off or od high
      st_nxt.pad_oe[i]  = oe & ~(md[GPPC_OD_BIT] & lvl);
      st_nxt.pad_out[i] = lvl & ~md[GPPC_OD_BIT];
      st_nxt.pad_pu[i]  = md[GPPC_PU_BIT] & ~(i == GPPC_TEST_PIN && debug_active);
      st_nxt.pin_fn_in[i] = ie & st_r.sync2[i];
    end

    // clock selection overrides crystal pin mode
    st_nxt.xt_en = st_r.clk_sel ? 2'b00 : st_r.xt_mode;

    // register reads
    if (bus_req.rd) begin
      if (port_a == GPPC_GLOBAL) begin
        case (reg_a)
          GPPC_REG_CLKSEL: rd = {15'h0000, st_r.clk_sel};
          GPPC_REG_XTMODE: rd = {7'h00, st_r.xt_mode[1], 7'h00, st_r.xt_mode[0]};
          GPPC_REG_XTDIN:  rd = {14'h0000, st_r.xsync2 & st_r.xt_en};
          default:         rd = 16'h0000;
        endcase
      end else if (32'(port_a) < NPORTS) begin
        p = 32'(port_a);
        if (reg_a < GPPC_REG_DOUT) begin
          rd = {8'h00, st_r.mode[p * GPPC_PINS + 32'(reg_a)]};
        end else if (reg_a == GPPC_REG_DOUT) begin
          rd = {8'h00, st_r.dout[p]};
        end else if (reg_a == GPPC_REG_DIN) begin
          for (int unsigned j = 0; j < GPPC_PINS; j++) begin
            md = st_r.mode[p * GPPC_PINS + j];
            if (!(p * GPPC_PINS + j == GPPC_TEST_PIN && debug_active)) begin
              if (md[GPPC_IE_BIT] && md[GPPC_OE_BIT]) begin
                rd[j] = st_r.drv_lvl[p * GPPC_PINS + j];
              end else if (md[GPPC_IE_BIT]) begin
                rd[j] = st_r.sync2[p * GPPC_PINS + j];
              end
            end
          end
        end else if (p < NCARRIER && reg_a == GPPC_REG_PMD) begin
          rd = st_r.pmd[p];
        end else if (p < NCARRIER && reg_a == GPPC_REG_PSL) begin
          rd = {8'h00, st_r.psl[p]};
        end
      end
    end
    st_nxt.rdata = rd;
  end

  //////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_r <= '0;
      for (int unsigned i = 0; i < NPIN; i++) begin
        st_r.mode[i] <= GPPC_MODE_RST;
      end
      st_r.mode[GPPC_BOOT_PIN] <= GPPC_BOOT_RST;
      for (int unsigned k = 0; k < NPORTS; k++) begin
        st_r.dout[k] <= GPPC_DOUT_RST;
      end
      for (int unsigned k = 0; k < NCR; k++) begin
        st_r.pmd[k] <= GPPC_PMD_RST;
        st_r.psl[k] <= GPPC_PSL_RST;
      end
      st_r.pad_pu[GPPC_BOOT_PIN] <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // outputs
  always_comb begin
    bus_rdata  = st_r.rdata;
    pin_out    = st_r.pad_out;
    pin_oe     = st_r.pad_oe;
    pin_pullup = st_r.pad_pu;
    periph_in  = st_r.pin_fn_in;
    xt_in_en   = st_r.xt_en;
    for (int unsigned i = 0; i < NPIN; i++) begin
      func_sel[i] = st_r.mode[i][GPPC_FN_LSB +: GPPC_FN_W];
    end
  end
endmodule : gppc_port_ctrl

// >>> testbench/gppc_port_ctrl_assertions.sv
// checker for the port pin control, sees the top module ports only
// assumes defaults of twelve ports and four carrier ports
module gppc_port_ctrl_chk
  import gppc_pkg::*;
#(
  parameter int unsigned NPORTS   = 12,
  parameter int unsigned NCARRIER = 4
) (
  input wire logic                                          clk,
  input wire logic                                          rst,
  input wire gppc_pkg::gppc_bus_req_type                    bus_req,
  input wire logic [gppc_pkg::GPPC_DW-1:0]                  bus_rdata,
  input wire logic [NPORTS*gppc_pkg::GPPC_PINS-1:0]         pin_in,
  input wire logic [NPORTS*gppc_pkg::GPPC_PINS-1:0]         pin_out,
  input wire logic [NPORTS*gppc_pkg::GPPC_PINS-1:0]         pin_oe,
  input wire logic [NPORTS*gppc_pkg::GPPC_PINS-1:0]         pin_pullup,
  input wire logic [NPORTS*gppc_pkg::GPPC_PINS-1:0][6:0]    alt_out,
  input wire logic [NPORTS*gppc_pkg::GPPC_PINS-1:0][3:0]    func_sel,
  input wire logic [NPORTS*gppc_pkg::GPPC_PINS-1:0]         periph_in,
  input wire logic                                          debug_active
);
  logic alt_r;
  logic fn_alt_r;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      alt_r    <= 1'b0;
      fn_alt_r <= 1'b0;
    end else begin
      fn_alt_r <= (func_sel[32] != 4'h0) && !func_sel[32][3];
      alt_r    <= alt_out[32][func_sel[32][2:0]-3'd1];
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  property p_reset_drive; $fell(rst) |-> pin_oe == '0 && pin_out == '0; endproperty
  a_reset_drive: assert property (p_reset_drive) else $error("drive after reset");
  property p_reset_pull; $fell(rst) |-> pin_pullup == 96'h2; endproperty
  a_reset_pull: assert property (p_reset_pull) else $error("pull after reset");
  property p_rdata_idle; !$past(bus_req.rd) |-> bus_rdata == 16'h0000; endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data stray");
  property p_alt_route; pin_oe[32] && fn_alt_r |-> pin_out[32] == alt_r; endproperty
  a_alt_route: assert property (p_alt_route) else $error("shared route");
  property p_periph_gate; periph_in[24] |-> $past(pin_in[24], 3); endproperty
  a_periph_gate: assert property (p_periph_gate) else $error("input level");
  property p_debug; debug_active [*2] |-> !pin_oe[0] && !pin_pullup[0] && !periph_in[0];
  endproperty
  a_debug: assert property (p_debug) else $error("test pin shared");
  property p_fsel_write; bus_req.wr && bus_req.addr == 8'h30 |=>
    func_sel[24] == $past(bus_req.wdata[7:4]); endproperty
  a_fsel_write: assert property (p_fsel_write) else $error("func field");
  property p_oe_write; bus_req.wr && bus_req.addr == 8'h30 && !bus_req.wdata[1] |=>
    ##1 !pin_oe[24]; endproperty
  a_oe_write: assert property (p_oe_write) else $error("driver not off");
  property p_pull_write; bus_req.wr && bus_req.addr == 8'h30 |=>
    ##1 pin_pullup[24] == $past(bus_req.wdata[2], 2); endproperty
  a_pull_write: assert property (p_pull_write) else $error("pull-up bit");
  c_alt: cover property (pin_oe[32] && fn_alt_r);
  c_periph: cover property (periph_in[24]);
  c_debug: cover property (debug_active [*2]);
endmodule : gppc_port_ctrl_chk
bind gppc_port_ctrl gppc_port_ctrl_chk #(.NPORTS(NPORTS), .NCARRIER(NCARRIER)) u_chk (
  .clk(clk), .rst(rst), .bus_req(bus_req), .bus_rdata(bus_rdata), .pin_in(pin_in),
  .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup(pin_pullup), .alt_out(alt_out),
  .func_sel(func_sel), .periph_in(periph_in), .debug_active(debug_active));

// >>> testbench/gppc_pad_model.sv
// pad and board model: drives pin levels seen by the port logic
// assumes undriven pins without pull-up float to a changing level
module gppc_pad_model (
  input wire logic        clk,
  input wire logic [95:0] pin_out,
  input wire logic [95:0] pin_oe,
  input wire logic [95:0] pin_pullup,
  input wire logic [95:0] ext_en,
  input wire logic [95:0] ext_val,
  output logic [95:0]     pin_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic flip_r = 1'b0;
  always @(posedge clk) flip_r <= !flip_r;
  always_comb begin
    for (int i = 0; i < 96; i++) begin
      pin_in[i] = pin_oe[i] ? pin_out[i] : ext_en[i] ? ext_val[i] : pin_pullup[i] | flip_r;
    end
  end
endmodule : gppc_pad_model

// >>> testbench/tb_general_port_pin_control.sv
// self-checking bench for the port pin control
// assumes the pad model on the pins and the bound checker
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin err_count++; \
  $display("wrong value t=%0t got %h exp %h", $time, a, b); end end
module tb_general_port_pin_control;
  import gppc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst = 1, debug_active = 0, timer0_out = 0, ftimer0_out = 0;
  gppc_bus_req_type bus_req = '0;
  logic [15:0] bus_rdata, d;
  logic [95:0] pin_in, pin_out, pin_oe, pin_pullup, periph_in, ext_en = '0, ext_val = '0;
  logic [95:0][6:0] alt_out = '0;
  logic [95:0][3:0] func_sel;
  logic [1:0] xt_in_en;
  int err_count = 0, n_tests = 0;
  always #2 clk = !clk;
  gppc_port_ctrl dut (.clk(clk), .rst(rst), .bus_req(bus_req), .bus_rdata(bus_rdata),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup(pin_pullup),
    .alt_out(alt_out), .func_sel(func_sel), .periph_in(periph_in), .timer0_out(timer0_out),
    .ftimer0_out(ftimer0_out), .debug_active(debug_active), .xt_pin_in(2'b11),
    .xt_in_en(xt_in_en));
  gppc_pad_model pads (.clk(clk), .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup(pin_pullup),
    .ext_en(ext_en), .ext_val(ext_val), .pin_in(pin_in));
  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    @(posedge clk) bus_req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge clk) bus_req.wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge clk) bus_req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge clk) bus_req.rd <= 1'b0;
    #1 d = bus_rdata;
  endtask : rd
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : settle
  task automatic t_reset;
    rd(8'h00); `CHK(d, 16'h0000)
    rd(8'h01); `CHK(d, 16'h0005)
    rd(8'h0B); `CHK(d, 16'h0000)
    `CHK(pin_pullup, 96'h2)
    `CHK(pin_oe, 96'h0)
  endtask : t_reset
  task automatic t_output;
    wr(8'h28, 16'h0055);
    for (int m = 0; m < 8; m++) wr({4'h2, 4'(m)}, 16'h0003);
    settle(2);
    `CHK(pin_oe[23:16], 8'hFF)
    `CHK(pin_out[23:16], 8'h55)
    rd(8'h29); `CHK(d, 16'h0055)
    wr(8'h20, 16'h000B);
    wr(8'h21, 16'h0000);
    wr(8'h23, 16'h000B);
    settle(2);
    `CHK(pin_oe[17:16], 2'b00)
    `CHK(pin_out[16], 1'b0)
    `CHK(pin_oe[19], 1'b1)
    `CHK(pin_out[19], 1'b0)
  endtask : t_output
  task automatic t_input;
    @(posedge clk);
    ext_en[24] <= 1'b1;
    ext_val[24] <= 1'b1;
    wr(8'h30, 16'h0005);
    settle(3);
    `CHK(pin_pullup[24], 1'b1)
    `CHK(periph_in[24], 1'b1)
    rd(8'h39); `CHK(d[0], 1'b1)
    @(posedge clk);
    ext_val[24] <= 1'b0;
    settle(4);
    rd(8'h39); `CHK(d[0], 1'b0)
    wr(8'h30, 16'h0001);
    settle(2);
    `CHK(pin_pullup[24], 1'b0)
    @(posedge clk);
    ext_val[24] <= 1'b1;
    wr(8'h30, 16'h0000);
    settle(4);
    rd(8'h39); `CHK(d[0], 1'b0)
  endtask : t_input
  task automatic t_func;
    for (int c = 0; c < 16; c++) begin
      @(posedge clk);
      alt_out[32] <= (c >= 1 && c <= 7) ? 7'(1 << (c - 1)) : 7'h7F;
      wr(8'h40, {8'h00, 4'(c), 4'h2});
      settle(2);
      `CHK(func_sel[32], 4'(c))
      `CHK(pin_out[32], (c >= 1 && c <= 7))
    end
  endtask : t_func
  task automatic t_carrier;
    wr(8'h08, 16'h0008);
    wr(8'h03, 16'h0002);
    wr(8'h0A, 16'h0008);
    for (int s = 0; s < 2; s++) begin
      wr(8'h0B, 16'(s << 3));
      for (int v = 0; v < 2; v++) begin
        @(posedge clk);
        timer0_out <= 1'(v);
        ftimer0_out <= !1'(v);
        settle(2);
        `CHK(pin_out[3], 1'(s ? !v : v))
      end
    end
    wr(8'h08, 16'h0000);
    wr(8'h0A, 16'h0808);
    wr(8'h0B, 16'h0000);
    for (int v = 0; v < 2; v++) begin
      @(posedge clk);
      timer0_out <= 1'(v);
      settle(2);
      `CHK(pin_out[3], 1'(v))
    end
  endtask : t_carrier
  task automatic t_misc;
    @(posedge clk);
    debug_active <= 1'b1;
    wr(8'h00, 16'h0007);
    settle(2);
    `CHK({pin_oe[0], pin_pullup[0]}, 2'b00)
    rd(8'h09); `CHK(d[0], 1'b0)
    @(posedge clk);
    debug_active <= 1'b0;
    settle(2);
    `CHK(pin_oe[0], 1'b1)
    wr(8'hF1, 16'h0101);
    settle(2);
    `CHK(xt_in_en, 2'b11)
    rd(8'hF2); `CHK(d, 16'h0003)
    wr(8'hF0, 16'h0001);
    settle(2);
    `CHK(xt_in_en, 2'b00)
    rd(8'hF2); `CHK(d, 16'h0000)
    wr(8'hB7, 16'h0071);
    rd(8'hB7); `CHK(d, 16'h0071)
    rd(8'hC0); `CHK(d, 16'h0000)
  endtask : t_misc
  task automatic close_out;
    if (err_count == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : close_out
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_output();
    t_input();
    t_func();
    t_carrier();
    t_misc();
    close_out();
  end
endmodule : tb_general_port_pin_control
